// [verilog/regbank_consts.svh]
// Constants for the register bank: address layout, masks, reset values.
`ifndef REGBANK_CONSTS_SVH
`define REGBANK_CONSTS_SVH

`define RB_DATA_W      8
`define RB_NUM_REGS    4
`define RB_IDX_W       2
`define RB_ALIAS_W     2

`define RB_ALIAS_BASE  2'h0
`define RB_ALIAS_SET   2'h1
`define RB_ALIAS_CLR   2'h2
`define RB_ALIAS_TGL   2'h3

`define RB_RW_MASK     32'h3f0f_0f0f
`define RB_RO_MASK     32'h00f0_f0f0
`define RB_WO_MASK     32'h4000_0000
`define RB_RESET_VAL   32'h0000_0501
`define RB_DEBUG_IDX   2'h3

`endif

// [verilog/regbank_pkg.sv]
// Types shared by the register bank modules.
package regbank_pkg;
   typedef enum logic [1:0] {
      ALIAS_BASE   = 2'b00,
      ALIAS_SET    = 2'b01,
      CLEAR_ALIAS  = 2'b10,
      TOGGLE_ALIAS = 2'b11
   } alias_sel_type;
endpackage

// [verilog/reg_store_if.sv]
// Carrier between the access logic and the register storage.
`timescale 1ns/1ps
interface reg_store_if #(
   parameter int N  = 4,
   parameter int W  = 8,
   parameter int IW = 2
);
   logic           wr_en;
   logic [IW-1:0]  wr_idx;
   logic [W-1:0]   wr_data;
   logic [N*W-1:0] words;

   modport access (output wr_en, output wr_idx, output wr_data, input words);
   modport store  (input wr_en, input wr_idx, input wr_data, output words);
endinterface

// [verilog/reg_store.sv]
// Storage words of the register bank with power-on and software reset.
`timescale 1ns/1ps
`include "regbank_consts.svh"
module reg_store #(
   parameter int             N         = `RB_NUM_REGS,
   parameter int             W         = `RB_DATA_W,
   parameter int             IW        = `RB_IDX_W,
   parameter logic [N*W-1:0] RESET_VAL = `RB_RESET_VAL,
   parameter logic [IW-1:0]  DEBUG_IDX = `RB_DEBUG_IDX
) (
   // Clock and resets
   input  wire logic clock_in,
   input  wire logic rst_in,
   input  wire logic soft_rst_in,
   // Access side
   reg_store_if.store io
);
   logic [N*W-1:0] words_ff;
   logic [N*W-1:0] nxt_words;

   always_comb begin
      nxt_words = words_ff;
      for (int i = 0; i < N; i++) begin
         if (soft_rst_in && (i != int'(DEBUG_IDX))) begin
            nxt_words[i*W +: W] = RESET_VAL[i*W +: W];
         end else if (io.wr_en && (io.wr_idx == IW'(i))) begin
            nxt_words[i*W +: W] = io.wr_data;
         end
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         words_ff <= RESET_VAL;
      end else begin
         words_ff <= nxt_words;
      end
   end

   assign io.words = words_ff;
endmodule

// [verilog/regbank.sv]
// Register bank with access classes, reserved bits and set/clear/toggle aliases.
`timescale 1ns/1ps
`include "regbank_consts.svh"

module regbank #(
   parameter int                   N         = `RB_NUM_REGS,
   parameter int                   W         = `RB_DATA_W,
   parameter int                   IW        = `RB_IDX_W,
   parameter logic [N*W-1:0]       RW_MASK   = `RB_RW_MASK,
   parameter logic [N*W-1:0]       RO_MASK   = `RB_RO_MASK,
   parameter logic [N*W-1:0]       WO_MASK   = `RB_WO_MASK,
   parameter logic [N*W-1:0]       RESET_VAL = `RB_RESET_VAL,
   parameter logic [IW-1:0]        DEBUG_IDX = `RB_DEBUG_IDX
) (
   // Clock and resets
   input  wire logic                          clock_in,
   input  wire logic                          rst_in,
   input  wire logic                          soft_rst_in,
   // Access port
   input  wire logic                          acc_wr_in,
   input  wire logic                          acc_rd_in,
   input  wire logic [IW+`RB_ALIAS_W-1:0]     acc_addr_in,
   input  wire logic [W-1:0]                  acc_wdata_in,
   output logic      [W-1:0]                  rd_data_out,
   output logic                               rd_valid_out,
   // Hardware side
   input  wire logic [N*W-1:0]                status_in,
   output logic      [N*W-1:0]                ctrl_out
);
   reg_store_if #(.N(N), .W(W), .IW(IW)) store_io ();

   reg_store #(
      .N         (N),
      .W         (W),
      .IW        (IW),
      .RESET_VAL (RESET_VAL & (RW_MASK | WO_MASK)),
      .DEBUG_IDX (DEBUG_IDX)
   ) u_store (
      .clock_in    (clock_in),
      .rst_in      (rst_in),
      .soft_rst_in (soft_rst_in),
      .io          (store_io.store)
   );

   logic [IW-1:0]               acc_idx;
   regbank_pkg::alias_sel_type  acc_sel;
   logic [W-1:0]                cur_word;
   logic [W-1:0]                rw_mask;
   logic [W-1:0]                ro_mask;
   logic [W-1:0]                new_word;
   logic [N*W-1:0]              upd_words;

   logic [W-1:0]                rd_data_ff;
   logic [W-1:0]                nxt_rd_data;
   logic                        rd_valid_ff;
   logic                        nxt_rd_valid;

   assign acc_idx  = acc_addr_in[IW+`RB_ALIAS_W-1:`RB_ALIAS_W];
   assign acc_sel  = regbank_pkg::alias_sel_type'(acc_addr_in[`RB_ALIAS_W-1:0]);

   // Storage never holds read-only or reserved bits, so they cannot be changed by any write.
   // Each register works out its alias update at once; the decoded index then picks one of them.
   for (genvar gi = 0; gi < N; gi++) begin : g_reg
      localparam logic [W-1:0] WR_MASK = RW_MASK[gi*W +: W] | WO_MASK[gi*W +: W];
      logic [W-1:0] stored;
      logic [W-1:0] hit_bits;
      logic [W-1:0] upd;

      assign stored   = store_io.words[gi*W +: W];
      assign hit_bits = acc_wdata_in & WR_MASK;

      always_comb begin
         case (acc_sel)
            regbank_pkg::ALIAS_BASE: begin
               upd = (stored & ~WR_MASK) | hit_bits;
            end
            regbank_pkg::ALIAS_SET: begin
               upd = stored | hit_bits;
            end
            regbank_pkg::CLEAR_ALIAS: begin
               upd = stored & ~hit_bits;
            end
            regbank_pkg::TOGGLE_ALIAS: begin
               upd = stored ^ hit_bits;
            end
            default: begin
               upd = stored;
            end
         endcase
      end

      assign upd_words[gi*W +: W] = upd;
   end

   always_comb begin
      cur_word = store_io.words[acc_idx*W +: W];
      rw_mask  = RW_MASK[acc_idx*W +: W];
      ro_mask  = RO_MASK[acc_idx*W +: W];
      new_word = upd_words[acc_idx*W +: W];
   end

   assign store_io.wr_en   = acc_wr_in;
   assign store_io.wr_idx  = acc_idx;
   assign store_io.wr_data = new_word;

   // The read ignores the alias code, so all four aliases of a register return the same word.
   always_comb begin
      nxt_rd_valid = acc_rd_in;
      nxt_rd_data  = rd_data_ff;
      if (acc_rd_in) begin
         nxt_rd_data = (cur_word & rw_mask)
                     | (status_in[acc_idx*W +: W] & ro_mask);
         // Write-only and reserved bits fall out of both masks and read zero.
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         rd_data_ff  <= '0;
         rd_valid_ff <= 1'b0;
      end else begin
         rd_data_ff  <= nxt_rd_data;
         rd_valid_ff <= nxt_rd_valid;
      end
   end

   assign rd_data_out  = rd_data_ff;
   assign rd_valid_out = rd_valid_ff;
   assign ctrl_out     = store_io.words;
endmodule

// [testbench/regbank_props.sv]
// Checker for the register bank port behaviour.
`timescale 1ns/1ps
module regbank_props (
   input wire logic        clock_in,
   input wire logic        rst_in,
   input wire logic        soft_rst_in,
   input wire logic        acc_wr_in,
   input wire logic        acc_rd_in,
   input wire logic [3:0]  acc_addr_in,
   input wire logic [7:0]  acc_wdata_in,
   input wire logic [7:0]  rd_data_out,
   input wire logic        rd_valid_out,
   input wire logic [31:0] status_in,
   input wire logic [31:0] ctrl_out
);
   localparam logic [31:0] WM = 32'h7f0f_0f0f;
   localparam logic [31:0] RM = 32'h3f0f_0f0f;
   localparam logic [31:0] RO = 32'h00f0_f0f0;
   localparam logic [31:0] WO = 32'h4000_0000;
   wire logic  [1:0]  idx = acc_addr_in[3:2];
   logic       [7:0]  old_b, new_b, exp_b, rbyte, defb;
   logic       [31:0] rview;
   always_comb begin
      old_b = ctrl_out[idx*8 +: 8];
      rview = (ctrl_out & RM) | (status_in & RO);
      rbyte = rview[idx*8 +: 8];
      // Write-only bits read back as zero, yet the read check still leaves them out.
      defb  = ~WO[idx*8 +: 8];
      case (acc_addr_in[1:0])
         2'h0: new_b = acc_wdata_in;
         2'h1: new_b = old_b | acc_wdata_in;
         2'h2: new_b = old_b & ~acc_wdata_in;
         default: new_b = old_b ^ acc_wdata_in;
      endcase
      exp_b = (new_b & WM[idx*8 +: 8]) | (old_b & ~WM[idx*8 +: 8]);
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   sequence s_answer;
      rd_valid_out && ((rd_data_out & $past(defb)) == $past(rbyte));
   endsequence
   a_rd_answer: assert property (acc_rd_in |=> s_answer)
      else $error("read answer wrong");
   a_rd_idle: assert property (!acc_rd_in |=> !rd_valid_out && $stable(rd_data_out))
      else $error("read outputs moved without read");
   a_no_change: assert property (!acc_wr_in && !soft_rst_in |=> $stable(ctrl_out))
      else $error("stored word changed without write");
   a_reserved_zero: assert property ((ctrl_out & ~WM) == 32'h0)
      else $error("reserved bit set");
   a_write_effect: assert property (acc_wr_in && !soft_rst_in |=> ctrl_out[$past(idx)*8 +: 8] == $past(exp_b))
      else $error("written byte wrong");
   a_other_bytes: assert property (acc_wr_in && !soft_rst_in |=>
      ((ctrl_out ^ $past(ctrl_out)) & ~(32'hff << ($past(idx)*8))) == 32'h0)
      else $error("unaddressed byte changed");
   a_soft_reset: assert property (soft_rst_in |=> ctrl_out[23:0] == 24'h00_0501)
      else $error("soft reset value wrong");
   a_debug_keep: assert property (soft_rst_in && !acc_wr_in |=> $stable(ctrl_out[31:24]))
      else $error("debug register lost on soft reset");
endmodule

// [testbench/regbank_test.sv]
// Self-checking bench for the register bank.
`timescale 1ns/1ps
module regbank_test;
   typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_type;
   logic        clock_in, rst_in, soft_rst_in, acc_wr_in, acc_rd_in, rd_valid_out;
   logic [3:0]  acc_addr_in;
   logic [7:0]  acc_wdata_in, rd_data_out;
   logic [31:0] status_in, ctrl_out;
   int          error_cnt, comparisons;
   // Write-only bits read back as zero, yet they are still masked out of the read compares in the row loop.
   localparam logic [31:0] WO_BITS = 32'h4000_0000;
   logic [7:0]  seen_byte;
   row_type     rows [9] = '{'{4'h0, 8'hff, 8'hcf}, '{4'h2, 8'h05, 8'hca}, '{4'h1, 8'h31, 8'hcb},
      '{4'h3, 8'h0f, 8'hc4}, '{4'h5, 8'h02, 8'hc7}, '{4'h7, 8'h06, 8'hc1}, '{4'hc, 8'hff, 8'h3f},
      '{4'he, 8'h41, 8'h3e}, '{4'h8, 8'ha5, 8'hc5}};
   // Only the 4'hc row sets a reserved bit, on purpose; every other write keeps reserved bits at zero.
   regbank dut (.clock_in(clock_in), .rst_in(rst_in), .soft_rst_in(soft_rst_in), .acc_wr_in(acc_wr_in),
      .acc_rd_in(acc_rd_in), .acc_addr_in(acc_addr_in), .acc_wdata_in(acc_wdata_in),
      .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .status_in(status_in), .ctrl_out(ctrl_out));
   always #12.5 clock_in = ~clock_in;
   task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s exp %h seen %h", n, exp, seen);
      end
   endtask
   task op(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
      @(negedge clock_in);
      {acc_wr_in, acc_rd_in, acc_addr_in, acc_wdata_in} = {w, r, a, d};
      @(negedge clock_in);
      {acc_wr_in, acc_rd_in} = 2'h0;
   endtask
   task report_and_stop;
      $display("Checks %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      {clock_in, soft_rst_in, acc_wr_in, acc_rd_in, acc_addr_in, acc_wdata_in} = '0;
      rst_in = 1'b1;
      status_in = 32'hc3c3_c3c3;
      repeat (3) @(negedge clock_in);
      rst_in = 1'b0;
      chk("reset ctrl", ctrl_out, 32'h0000_0501);
      foreach (rows[i]) begin
         op(1'b1, 1'b0, rows[i].a, rows[i].d);
         op(1'b0, 1'b1, rows[i].a, 8'h00);
         seen_byte = rd_data_out & ~WO_BITS[rows[i].a[3:2]*8 +: 8];
         chk("read byte", {rd_valid_out, seen_byte}, {1'b1, rows[i].e});
      end
      // Soft reset must spare the debug word while the others reload.
      @(negedge clock_in);
      soft_rst_in = 1'b1;
      @(negedge clock_in);
      soft_rst_in = 1'b0;
      chk("soft reset ctrl", ctrl_out, 32'h3e00_0501);
      op(1'b1, 1'b1, 4'h0, 8'h00);
      chk("read before write", rd_data_out, 32'hc1);
      status_in = 32'h0;
      op(1'b0, 1'b1, 4'h1, 8'h00);
      chk("read after write", rd_data_out, 32'h00);
      @(negedge clock_in);
      chk("valid one cycle", rd_valid_out, 32'h0);
      // Soft reset spares a write to the debug word but beats a write to any other word.
      {soft_rst_in, acc_wr_in, acc_addr_in, acc_wdata_in} = {2'h3, 4'hd, 8'h41};
      @(negedge clock_in);
      {acc_addr_in, acc_wdata_in} = {4'h0, 8'h0f};
      @(negedge clock_in);
      {soft_rst_in, acc_wr_in} = 2'h0;
      chk("soft reset with write", ctrl_out, 32'h7f00_0501);
      status_in = 32'hc3c3_c3c3;
      op(1'b0, 1'b1, 4'h6, 8'h00);
      chk("status view", rd_data_out, 32'hc5);
      // A second power-on reset in mid-run also reloads the debug word.
      @(negedge clock_in);
      rst_in = 1'b1;
      @(negedge clock_in);
      rst_in = 1'b0;
      chk("reset ctrl again", ctrl_out, 32'h0000_0501);
      chk("reset read outputs", {rd_valid_out, rd_data_out}, 32'h0);
      op(1'b1, 1'b0, 4'h5, 8'h0a);
      op(1'b0, 1'b1, 4'h4, 8'h00);
      chk("first write after reset", rd_data_out, 32'hcf);
      report_and_stop;
   end
   initial begin
      #20000;
      error_cnt++;
      report_and_stop;
   end
endmodule
bind regbank regbank_props props_i (.clock_in, .rst_in, .soft_rst_in, .acc_wr_in, .acc_rd_in, .acc_addr_in,
   .acc_wdata_in, .rd_data_out, .rd_valid_out, .status_in, .ctrl_out);
